// *** rtl/dcl_params.svh ***
`ifndef DCL_PARAMS_SVH
`define DCL_PARAMS_SVH
// ***************************************************************
// register indexes (byte address = index * 4)
// ***************************************************************
`define DCL_IDX_CTRL       10'h000
`define DCL_IDX_DACCLK     10'h001
`define DCL_IDX_REFCLK     10'h002
`define DCL_IDX_INTERP     10'h003
`define DCL_IDX_LINK       10'h004
`define DCL_IDX_STATUS     10'h005
`define DCL_IDX_COUNT      10'h006
`define DCL_IDX_LANE       10'h007
`define DCL_IDX_PAGE       10'h008
`define DCL_IDX_FEAT       10'h009
`define DCL_IDX_CAL        10'h00A
`define DCL_IDX_LO_DIV     10'h08B
`define DCL_IDX_REF_DIV    10'h08C
`define DCL_IDX_VCO_A      10'h1B5
`define DCL_IDX_VCO_B      10'h1BB
`define DCL_IDX_VCO_C      10'h1C5
// ***************************************************************
// clock plan limits, MHz; lane limits in Mbps, loop count limits unitless
// ***************************************************************
`define DCL_DAC_MIN        12'h1A4
`define DCL_DAC_LO1        12'h5DC
`define DCL_DAC_LO2        12'h2EE
`define DCL_DAC_MAX        12'hAF0
`define DCL_REF_B1         10'h050
`define DCL_REF_B2         10'h0A0
`define DCL_REF_B3         10'h140
`define DCL_REF_B4         10'h280
`define DCL_REF_MIN        10'h023
`define DCL_REF_MAX        10'h3E8
`define DCL_VCO_MIN        17'h01770
`define DCL_VCO_MAX        17'h02EE0
`define DCL_VCO_B1         17'h0189C
`define DCL_VCO_B2         17'h01C52
`define DCL_CNT_MIN        16'h0006
`define DCL_CNT_MAX        16'h007F
`define DCL_RATE_FULL      12'h424
`define DCL_RATE_X4        12'h2BC
`define DCL_RATE_X8        12'h15E
`define DCL_LANE_MIN       20'h005A0
`define DCL_LANE_MAX       20'h02990
`define DCL_LANE_MULT      20'h00014
// ***************************************************************
// vco tuning values per band
// ***************************************************************
`define DCL_VCO_A_LO       8'h08
`define DCL_VCO_A_HI       8'h09
`define DCL_VCO_B_LO       8'h03
`define DCL_VCO_B_HI       8'h13
`define DCL_VCO_C_LO       8'h07
`define DCL_VCO_C_HI       8'h06
// ***************************************************************
// interpolation codes, sample format, feature reset values
// ***************************************************************
`define DCL_INTERP_X1      8'h00
`define DCL_INTERP_X2      8'h01
`define DCL_INTERP_X4      8'h03
`define DCL_INTERP_X8      8'h04
`define DCL_SAMPLE_BITS    5'h10
`define DCL_K_LONG         6'h20
`define DCL_K_SHORT        6'h10
`define DCL_FEAT_RESET     32'h00001B02
`define DCL_GAIN_TENTH_DB  8'h1B
`endif

// *** rtl/dcl_pkg.sv ***
`default_nettype none
`include "dcl_params.svh"
package dcl_pkg;
  // one row of the operating mode table
  typedef struct packed {
    logic       ok;          // mode exists
    logic       single_only; // not allowed with two links
    logic       k_long_only; // multiframe must be long
    logic [2:0] m;           // converters
    logic [3:0] l;           // lanes
    logic [1:0] l_log;       // log2 of lanes
    logic [2:0] f;           // octets per frame
    logic [1:0] s;           // samples per frame
  } dcl_mode_t;

  // mode table lookup shared by both ends
  function automatic dcl_mode_t dcl_mode(input logic [3:0] mode);
    dcl_mode_t r;
    r = '0;
    r.ok = 1'b1;
    case (mode)
      4'h0: r = '{1'b1, 1'b1, 1'b1, 3'h4, 4'h8, 2'h3, 3'h1, 2'h1};
      4'h1: r = '{1'b1, 1'b1, 1'b0, 3'h4, 4'h8, 2'h3, 3'h2, 2'h2};
      4'h2: r = '{1'b1, 1'b1, 1'b0, 3'h4, 4'h4, 2'h2, 3'h2, 2'h1};
      4'h3: r = '{1'b1, 1'b1, 1'b0, 3'h4, 4'h2, 2'h1, 3'h4, 2'h1};
      4'h4: r = '{1'b1, 1'b0, 1'b1, 3'h2, 4'h4, 2'h2, 3'h1, 2'h1};
      4'h5: r = '{1'b1, 1'b0, 1'b0, 3'h2, 4'h4, 2'h2, 3'h2, 2'h2};
      4'h6: r = '{1'b1, 1'b0, 1'b0, 3'h2, 4'h2, 2'h1, 3'h2, 2'h1};
      4'h7: r = '{1'b1, 1'b0, 1'b0, 3'h2, 4'h1, 2'h0, 3'h4, 2'h1};
      4'h9: r = '{1'b1, 1'b0, 1'b1, 3'h1, 4'h2, 2'h1, 3'h1, 2'h1};
      4'hA: r = '{1'b1, 1'b0, 1'b0, 3'h1, 4'h1, 2'h0, 3'h2, 2'h1};
      default: r = '0;
    endcase
    return r;
  endfunction
endpackage
`default_nettype wire

// *** rtl/dcl_link_if.sv ***
`default_nettype none
// link parameters as the transmitter announces them
interface dcl_link_if;
  logic       tx_valid;     // transmitter parameters stable
  logic [3:0] tx_mode;      // operating mode
  logic       tx_two_link;  // two links
  logic       tx_scramble;  // scrambling on
  logic       tx_subclass;  // deterministic latency
  logic [3:0] tx_l;         // lanes
  logic [2:0] tx_f;         // octets per frame
  logic [5:0] tx_k;         // frames per multiframe
  logic [2:0] tx_m;         // converters
  logic [4:0] tx_n;         // resolution
  logic [4:0] tx_np;        // bits per sample
  logic [1:0] tx_s;         // samples per frame
  logic       tx_hd;        // high density
  logic       link_enable;  // receiver armed
  logic       rx_match;     // receiver agrees with transmitter
  modport dac (input tx_valid, tx_mode, tx_two_link, tx_scramble,
               tx_subclass, tx_l, tx_f, tx_k, tx_m, tx_n, tx_np,
               tx_s, tx_hd, output link_enable, rx_match);
  modport tx (output tx_valid, tx_mode, tx_two_link, tx_scramble,
              tx_subclass, tx_l, tx_f, tx_k, tx_m, tx_n, tx_np,
              tx_s, tx_hd, input link_enable, rx_match);
endinterface
`default_nettype wire

// *** rtl/dcl_tx_end.sv ***
`default_nettype none
`include "dcl_params.svh"
// transmitter side: announces parameters it will send with
module dcl_tx_end (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // user settings
  input  wire logic       cfg_load,
  input  wire logic [3:0] cfg_mode,
  input  wire logic       cfg_two_link,
  input  wire logic       cfg_scramble,
  input  wire logic       cfg_subclass,
  input  wire logic       cfg_k_long,
  // user status
  output logic            tx_running,
  output logic            tx_cfg_bad,
  // link side
  dcl_link_if.tx          link
);
  // ***************************************************************
  // parameter set
  // ***************************************************************
  dcl_pkg::dcl_mode_t row;   // table row of requested mode
  logic               ok;    // request is a legal set
  assign row = dcl_pkg::dcl_mode(cfg_mode);
  assign ok  = row.ok & ~(row.single_only & cfg_two_link)
             & (cfg_k_long | ~row.k_long_only);

  // load parameters; a bad set is refused and keeps the old one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.tx_valid    <= 1'b0;
      link.tx_mode     <= 4'h0;
      link.tx_two_link <= 1'b0;
      link.tx_scramble <= 1'b0;
      link.tx_subclass <= 1'b0;
      link.tx_l        <= 4'h0;
      link.tx_f        <= 3'h0;
      link.tx_k        <= 6'h00;
      link.tx_m        <= 3'h0;
      link.tx_n        <= 5'h00;
      link.tx_np       <= 5'h00;
      link.tx_s        <= 2'h0;
      link.tx_hd       <= 1'b0;
      tx_cfg_bad       <= 1'b0;
    end else if (cfg_load) begin
      tx_cfg_bad <= ~ok;
      if (ok) begin
        link.tx_valid    <= 1'b1;
        link.tx_mode     <= cfg_mode;
        link.tx_two_link <= cfg_two_link;
        link.tx_scramble <= cfg_scramble;
        link.tx_subclass <= cfg_subclass;
        link.tx_l        <= row.l;
        link.tx_f        <= row.f;
        link.tx_m        <= row.m;
        link.tx_s        <= row.s;
        link.tx_k        <= cfg_k_long ? `DCL_K_LONG : `DCL_K_SHORT;
        link.tx_n        <= `DCL_SAMPLE_BITS;
        link.tx_np       <= `DCL_SAMPLE_BITS;
        link.tx_hd       <= (row.f == 3'h1);
      end
    end
  end

  // send only when receiver is armed and agrees
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_running <= 1'b0;
    end else begin
      tx_running <= link.tx_valid & link.link_enable & link.rx_match;
    end
  end
endmodule
`default_nettype wire

// *** rtl/dcl_dac_end.sv ***
// Local design decision: the APB register port.
`default_nettype none
`include "dcl_params.svh"
// Overview of operation
// - lo divider by dac clock band
// - ref divider code sets power-of-two factor
// - vco is dac clock times 2^(lo+1), 6-12 GHz
// - loop count from clocks, 6 to 127
// - vco tuning values chosen by vco band
// - zero to three doubling interpolation stages
// - interpolation codes 0,1,3,4 only
// - data rate limit per interpolation mode
// - transmitter parameters must match receiver
// - single-link modes 0-3 table
// - single or dual modes 4-7, 9, 10 table
// - lane rate 20*data*M/L, 1.44-10.64 Gbps
// - high density set exactly when F is 1
// - N and NP are always 16
// - K 32 for modes 0,4,9 else 16/32
// - features paged, writable any time; calibration unpaged
// - feature reset values fixed
// - dual link uses identical parameters
module dcl_dac_end (
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // configuration results
  output logic             cfg_valid,
  output logic [7:0]       interp_code,
  // link side
  dcl_link_if.dac          link
);
  // ***************************************************************
  // register storage
  // ***************************************************************
  logic [11:0] dac_mhz;      // dac clock, MHz
  logic [9:0]  ref_mhz;      // reference clock, MHz
  logic [8:0]  link_cfg;     // mode/two/scr/klong/subclass/enable
  logic        page;         // dual page select
  logic [31:0] feat [2];     // per-dual optional features
  logic        self_cal;     // unpaged calibration enable
  logic [7:0]  lo_reg;       // clock_lo_divider
  logic [7:0]  ref_reg;      // clock_ref_divider
  logic [7:0]  vco_a;        // vco_tuning_a
  logic [7:0]  vco_b;        // vco_tuning_b
  logic [7:0]  vco_c;        // vco_tuning_c
  logic [7:0]  status;       // latched check results
  logic [15:0] count_q;      // latched loop count
  logic [19:0] lane_q;       // latched lane rate, Mbps

  // ***************************************************************
  // clock plan
  // ***************************************************************
  logic [1:0]  lo_sel;       // computed lo divider code
  logic [2:0]  ref_sel;      // computed ref divider code
  logic [16:0] vco_mhz;      // vco frequency
  logic [15:0] count;        // feedback loop count
  logic        vco_ok;
  logic        cnt_ok;

  // band decode of dac clock
  always_comb begin
    if (dac_mhz >= `DCL_DAC_LO1) begin
      lo_sel = 2'h1;
    end else if (dac_mhz >= `DCL_DAC_LO2) begin
      lo_sel = 2'h2;
    end else begin
      lo_sel = 2'h3;
    end
  end

  // band decode of reference; factor is 2^code
  always_comb begin
    if (ref_mhz < `DCL_REF_B1) begin
      ref_sel = 3'h0;
    end else if (ref_mhz < `DCL_REF_B2) begin
      ref_sel = 3'h1;
    end else if (ref_mhz < `DCL_REF_B3) begin
      ref_sel = 3'h2;
    end else if (ref_mhz < `DCL_REF_B4) begin
      ref_sel = 3'h3;
    end else begin
      ref_sel = 3'h4;
    end
  end

  // shift amount kept at three bits: code 3 must multiply by 16
  assign vco_mhz = {5'h00, dac_mhz} << (3'(lo_sel) + 3'h1);
  assign vco_ok  = (vco_mhz >= `DCL_VCO_MIN)
                 & (vco_mhz <= `DCL_VCO_MAX);
  // a zero reference would divide by zero, so it is forced invalid
  assign count = (ref_mhz == 10'h000) ? 16'h0000 :
                 16'(({4'h0, dac_mhz} << ref_sel)
                     / {5'h00, ref_mhz, 1'b0});
  assign cnt_ok = (count >= `DCL_CNT_MIN) & (count <= `DCL_CNT_MAX)
                & (dac_mhz >= `DCL_DAC_MIN) & (dac_mhz <= `DCL_DAC_MAX)
                & (ref_mhz >= `DCL_REF_MIN)
                & (ref_mhz <= `DCL_REF_MAX);

  // ***************************************************************
  // datapath rate and link
  // ***************************************************************
  dcl_pkg::dcl_mode_t row;   // table row of selected mode
  logic [1:0]  ip_log;       // number of doubling stages
  logic        ip_ok;        // interpolation code defined
  logic [11:0] rate_max;     // data rate limit
  logic [11:0] data_mhz;     // data rate
  logic [19:0] lane_mbps;    // lane rate
  logic        rate_ok;
  logic        lane_ok;
  logic        k_ok;
  logic        mode_ok;
  logic        match;

  // interpolation code decode
  always_comb begin
    ip_ok    = 1'b1;
    ip_log   = 2'h0;
    rate_max = `DCL_RATE_FULL;
    case (interp_code)
      `DCL_INTERP_X1: ip_log = 2'h0;
      `DCL_INTERP_X2: ip_log = 2'h1;
      `DCL_INTERP_X4: begin
        ip_log   = 2'h2;
        rate_max = `DCL_RATE_X4;
      end
      `DCL_INTERP_X8: begin
        ip_log   = 2'h3;
        rate_max = `DCL_RATE_X8;
      end
      default: ip_ok = 1'b0;
    endcase
  end

  assign row       = dcl_pkg::dcl_mode(link_cfg[3:0]);
  assign data_mhz  = dac_mhz >> ip_log;
  assign rate_ok   = ip_ok & (data_mhz <= rate_max);
  assign lane_mbps = (20'(data_mhz) * `DCL_LANE_MULT
                      * 20'(row.m)) >> row.l_log;
  assign lane_ok   = (lane_mbps >= `DCL_LANE_MIN)
                   & (lane_mbps <= `DCL_LANE_MAX);
  assign k_ok      = link_cfg[6] | ~row.k_long_only;
  assign mode_ok   = row.ok & ~(row.single_only & link_cfg[4]);
  // receiver and transmitter must agree on every parameter
  assign match = link.tx_valid
    & (link.tx_mode == link_cfg[3:0])
    & (link.tx_two_link == link_cfg[4])
    & (link.tx_scramble == link_cfg[5])
    & (link.tx_subclass == link_cfg[7])
    & (link.tx_k == (link_cfg[6] ? `DCL_K_LONG : `DCL_K_SHORT))
    & (link.tx_l == row.l) & (link.tx_f == row.f)
    & (link.tx_m == row.m) & (link.tx_s == row.s)
    & (link.tx_hd == (row.f == 3'h1))
    & (link.tx_n == `DCL_SAMPLE_BITS)
    & (link.tx_np == `DCL_SAMPLE_BITS);

  // check results are latched so all outputs come from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status     <= 8'h00;
      count_q    <= 16'h0000;
      lane_q     <= 20'h00000;
      cfg_valid  <= 1'b0;
      link.rx_match <= 1'b0;
    end else begin
      status  <= {match, mode_ok, rate_ok, k_ok, lane_ok, cnt_ok, vco_ok,
                  vco_ok & cnt_ok & lane_ok & k_ok & rate_ok & mode_ok};
      count_q <= count;
      lane_q  <= lane_mbps;
      cfg_valid <= vco_ok & cnt_ok & lane_ok & k_ok
                 & rate_ok & mode_ok;
      link.rx_match <= match;
    end
  end

  // ***************************************************************
  // apb slave: one wait-free access phase, answer registered
  // ***************************************************************
  logic [9:0]  idx;          // word index
  logic        wr_en;        // write takes effect
  logic        known;        // address decodes
  logic [31:0] rd_val;       // read mux
  assign idx   = paddr[11:2];
  assign wr_en = psel & penable & pready & pwrite;

  // read decode, also tells whether an index is mapped
  always_comb begin
    known  = 1'b1;
    rd_val = 32'h00000000;
    case (idx)
      `DCL_IDX_CTRL:    rd_val = 32'h00000000;
      `DCL_IDX_DACCLK:  rd_val = {20'h00000, dac_mhz};
      `DCL_IDX_REFCLK:  rd_val = {22'h000000, ref_mhz};
      `DCL_IDX_INTERP:  rd_val = {24'h000000, interp_code};
      `DCL_IDX_LINK:    rd_val = {23'h000000, link_cfg};
      `DCL_IDX_STATUS:  rd_val = {24'h000000, status};
      `DCL_IDX_COUNT:   rd_val = {16'h0000, count_q};
      `DCL_IDX_LANE:    rd_val = {12'h000, lane_q};
      `DCL_IDX_PAGE:    rd_val = {31'h00000000, page};
      `DCL_IDX_FEAT:    rd_val = feat[page];
      `DCL_IDX_CAL:     rd_val = {31'h00000000, self_cal};
      `DCL_IDX_LO_DIV:  rd_val = {24'h000000, lo_reg};
      `DCL_IDX_REF_DIV: rd_val = {24'h000000, ref_reg};
      `DCL_IDX_VCO_A:   rd_val = {24'h000000, vco_a};
      `DCL_IDX_VCO_B:   rd_val = {24'h000000, vco_b};
      `DCL_IDX_VCO_C:   rd_val = {24'h000000, vco_c};
      default:          known  = 1'b0;
    endcase
  end

  // pready rises in the cycle after setup; data latched with it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      prdata  <= (psel & ~penable & ~pwrite) ? rd_val : 32'h00000000;
      pslverr <= psel & ~penable & ~known;
    end
  end

  // ***************************************************************
  // register writes
  // ***************************************************************
  logic hit_ok;              // mapped write
  assign hit_ok = wr_en & known;

  // clock and link settings; interpolation frozen while link_cfg enable bit 8 is set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac_mhz     <= 12'h000;
      ref_mhz     <= 10'h000;
      interp_code <= 8'h00;
      link_cfg    <= 9'h000;
      page        <= 1'b0;
      self_cal    <= 1'b0;
    end else if (hit_ok) begin
      case (idx)
        `DCL_IDX_DACCLK: dac_mhz <= pwdata[11:0];
        `DCL_IDX_REFCLK: ref_mhz <= pwdata[9:0];
        `DCL_IDX_INTERP: begin
          if (!link_cfg[8]) begin
            interp_code <= pwdata[7:0];
          end
        end
        `DCL_IDX_LINK:   link_cfg <= pwdata[8:0];
        `DCL_IDX_PAGE:   page     <= pwdata[0];
        `DCL_IDX_CAL:    self_cal <= pwdata[0];
        default:         page     <= page;
      endcase
    end
  end

  // optional features, one set per dual, open at any time
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_feat
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          feat[gi] <= `DCL_FEAT_RESET;
        end else if (hit_ok && idx == `DCL_IDX_FEAT && page == gi) begin
          feat[gi] <= pwdata;
        end
      end
    end
  endgenerate

  // documented divider and tuning registers; writing ctrl bit 0
  // loads them from the computed plan
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lo_reg  <= 8'h00;
      ref_reg <= 8'h00;
      vco_a   <= 8'h00;
      vco_b   <= 8'h00;
      vco_c   <= 8'h00;
    end else if (hit_ok && idx == `DCL_IDX_CTRL && pwdata[0]) begin
      lo_reg  <= {6'h00, lo_sel};
      ref_reg <= {5'h00, ref_sel};
      if (vco_mhz < `DCL_VCO_B1) begin
        vco_a <= `DCL_VCO_A_LO;
        vco_b <= `DCL_VCO_B_LO;
        vco_c <= `DCL_VCO_C_LO;
      end else if (vco_mhz < `DCL_VCO_B2) begin
        vco_a <= `DCL_VCO_A_HI;
        vco_b <= `DCL_VCO_B_LO;
        vco_c <= `DCL_VCO_C_HI;
      end else begin
        vco_a <= `DCL_VCO_A_HI;
        vco_b <= `DCL_VCO_B_HI;
        vco_c <= `DCL_VCO_C_HI;
      end
    end else if (hit_ok) begin
      case (idx)
        `DCL_IDX_LO_DIV:  lo_reg  <= pwdata[7:0];
        `DCL_IDX_REF_DIV: ref_reg <= pwdata[7:0];
        `DCL_IDX_VCO_A:   vco_a   <= pwdata[7:0];
        `DCL_IDX_VCO_B:   vco_b   <= pwdata[7:0];
        `DCL_IDX_VCO_C:   vco_c   <= pwdata[7:0];
        default:          vco_a   <= vco_a;
      endcase
    end
  end

  // receiver armed only when the whole set checks out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.link_enable <= 1'b0;
    end else begin
      link.link_enable <= link_cfg[8] & cfg_valid;
    end
  end
endmodule
`default_nettype wire

// *** dv/dcl_link_assertions.sv ***
`default_nettype none
// ****************
// link checker
// ****************
module dcl_link_checker (
  // clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // link levels
  input wire logic       tx_valid,
  input wire logic [3:0] tx_mode,
  input wire logic       tx_two_link,
  input wire logic [3:0] tx_l,
  input wire logic [2:0] tx_f,
  input wire logic [5:0] tx_k,
  input wire logic [2:0] tx_m,
  input wire logic [4:0] tx_n,
  input wire logic [4:0] tx_np,
  input wire logic       tx_hd,
  input wire logic       rx_match
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // density flag follows frame size
  chk_hd_flag: assert property (tx_valid |-> tx_hd == (tx_f == 3'h1))
    else $error("hd flag wrong");
  chk_sample_width: assert property (tx_valid |->
    tx_n == 5'h10 && tx_np == 5'h10) else $error("n or np wrong");
  chk_k_long: assert property (tx_valid && tx_mode inside {0, 4, 9}
    |-> tx_k == 6'h20) else $error("short k in long-only mode");
  chk_k_legal: assert property (tx_valid |->
    tx_k inside {6'h10, 6'h20}) else $error("k out of set");
  // modes 0..3 cannot run as two links
  chk_two_link: assert property (tx_valid && tx_two_link |->
    tx_mode >= 4'h4) else $error("dual link in single mode");
  chk_wide_mode: assert property (tx_valid && tx_mode < 4'h4 |->
    tx_m == 3'h4) else $error("m wrong in wide mode");
  chk_mode_five: assert property (tx_valid && tx_mode == 4'h5 |->
    tx_m == 3'h2 && tx_l == 4'h4 && tx_f == 3'h2) else $error("mode 5 row");
  // agreement only follows announced parameters
  chk_match_lag: assert property ($rose(rx_match) |->
    $past(tx_valid)) else $error("match without parameters");
  cover property (tx_valid && tx_two_link);
  cover property ($rose(rx_match));
  cover property ($fell(rx_match));
endmodule
`default_nettype wire

// *** dv/dac_clock_link_mode_config_tb.sv ***
`default_nettype none
`include "dcl_params.svh"
// ****************
// bench top
// ****************
module dac_clock_link_mode_config_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 1'b0;     // 50 MHz
  logic        presetn = 1'b0;  // active low
  logic        psel = 1'b0;     // apb request
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        cfg_valid;
  logic [7:0]  interp_code;
  logic        cfg_load = 1'b0; // tx user side
  logic [3:0]  cfg_mode = 4'h0;
  logic        cfg_two_link = 1'b0;
  logic        cfg_scramble = 1'b1;
  logic        cfg_subclass = 1'b1;
  logic        cfg_k_long = 1'b0;
  logic        tx_running;
  logic        tx_cfg_bad;
  logic [31:0] rd;              // last read word
  logic        err;             // last slave error
  int          n_mismatch = 0;
  int          n_checks = 0;
  int          i;
  int          j;
  // plan cases: dac MHz, ref MHz, {lane, lo, ref, count, vco a b c}
  logic [11:0] dac [4] = '{12'h258, 12'h7D0, 12'h618, 12'h6A4};
  logic [9:0]  rfq [4] = '{10'h2BC, 10'h064, 10'h1F4, 10'h023};
  logic [63:0] exq [4] = '{64'h05DC030406091306, 64'h1388010114091306,
                           64'h0F3C01030C080307, 64'h109A010018090306};
  logic [9:0]  idx [6] = '{`DCL_IDX_LANE, `DCL_IDX_LO_DIV, `DCL_IDX_REF_DIV,
                           `DCL_IDX_COUNT, `DCL_IDX_VCO_A, `DCL_IDX_VCO_B};
  logic [7:0]  codes [4] = '{8'h00, 8'h01, 8'h03, 8'h04};
  logic        okq [4] = '{1'b0, 1'b1, 1'b1, 1'b1}; // 1x too fast at 1700
  dcl_link_if link ();
  dcl_dac_end dcl_dac_end_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .cfg_valid(cfg_valid), .interp_code(interp_code), .link(link));
  dcl_tx_end dcl_tx_end_inst (.pclk(pclk), .presetn(presetn),
    .cfg_load(cfg_load), .cfg_mode(cfg_mode), .cfg_two_link(cfg_two_link),
    .cfg_scramble(cfg_scramble), .cfg_subclass(cfg_subclass),
    .cfg_k_long(cfg_k_long), .tx_running(tx_running),
    .tx_cfg_bad(tx_cfg_bad), .link(link));
  dcl_link_checker dcl_link_checker_inst (.pclk(pclk), .presetn(presetn),
    .tx_valid(link.tx_valid), .tx_mode(link.tx_mode),
    .tx_two_link(link.tx_two_link), .tx_l(link.tx_l), .tx_f(link.tx_f),
    .tx_k(link.tx_k), .tx_m(link.tx_m), .tx_n(link.tx_n),
    .tx_np(link.tx_np), .tx_hd(link.tx_hd), .rx_match(link.rx_match));
  always #10 pclk = ~pclk;
  // one compare for every result
  task automatic chk(input string what, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {a, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        chk("pready", 32'h1, 32'h0);
        report_and_stop();
      end
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // load tx settings; walk settles within a few cycles
  task automatic tx_load(input logic [3:0] m, input logic two, kl);
    cfg_load <= 1'b1;
    cfg_mode <= m;
    cfg_two_link <= two;
    cfg_k_long <= kl;
    @(posedge pclk);
    cfg_load <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `DCL_IDX_FEAT, 32'h0);
    chk("feat", `DCL_FEAT_RESET, rd);
    apb(1'b0, `DCL_IDX_CAL, 32'h0);
    chk("cal", 32'h0, rd);
    apb(1'b0, 10'h00B, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    apb(1'b1, `DCL_IDX_LINK, 32'h5);
    apb(1'b1, `DCL_IDX_INTERP, 32'h3);
    for (i = 0; i < 4; i++) begin
      apb(1'b1, `DCL_IDX_DACCLK, {20'h0, dac[i]});
      apb(1'b1, `DCL_IDX_REFCLK, {22'h0, rfq[i]});
      apb(1'b1, `DCL_IDX_CTRL, 32'h1);
      for (j = 0; j < 6; j++) begin
        apb(1'b0, idx[j], 32'h0);
        chk("plan", j == 0 ? {16'h0, exq[i][63:48]} :
            {24'h0, exq[i][8*(6-j) +: 8]}, rd);
      end
      apb(1'b0, `DCL_IDX_VCO_C, 32'h0);
      chk("vco c", {24'h0, exq[i][7:0]}, rd);
      chk("valid", 32'h1, {31'h0, cfg_valid});
    end
    for (i = 0; i < 4; i++) begin
      apb(1'b1, `DCL_IDX_INTERP, {24'h0, codes[i]});
      repeat (2) @(posedge pclk);
      chk("interp", {24'h0, codes[i]}, {24'h0, interp_code});
      chk("rate", {31'h0, okq[i]}, {31'h0, cfg_valid});
    end
    apb(1'b1, `DCL_IDX_INTERP, 32'h3);
    apb(1'b1, `DCL_IDX_LINK, 32'h4);
    repeat (2) @(posedge pclk);
    chk("k short", 32'h0, {31'h0, cfg_valid});
    apb(1'b1, `DCL_IDX_LINK, 32'h1B5);
    tx_load(4'h5, 1'b1, 1'b0);
    chk("enable", 32'h1, {31'h0, link.link_enable});
    chk("running", 32'h1, {31'h0, tx_running});
    apb(1'b1, `DCL_IDX_INTERP, 32'h1);
    apb(1'b0, `DCL_IDX_INTERP, 32'h0);
    chk("interp locked", 32'h3, rd);
    apb(1'b1, `DCL_IDX_FEAT, 32'h00001B03);
    apb(1'b0, `DCL_IDX_FEAT, 32'h0);
    chk("feat live", 32'h00001B03, rd);
    apb(1'b1, `DCL_IDX_PAGE, 32'h1);
    apb(1'b0, `DCL_IDX_FEAT, 32'h0);
    chk("feat page", `DCL_FEAT_RESET, rd);
    apb(1'b1, `DCL_IDX_CAL, 32'h1);
    apb(1'b0, `DCL_IDX_CAL, 32'h0);
    chk("cal set", 32'h1, rd);
    tx_load(4'h2, 1'b1, 1'b0);
    chk("bad dual", 32'h1, {31'h0, tx_cfg_bad});
    chk("kept", 32'h1, {31'h0, tx_running});
    tx_load(4'h4, 1'b0, 1'b0);
    chk("bad k", 32'h1, {31'h0, tx_cfg_bad});
    tx_load(4'h4, 1'b0, 1'b1);
    chk("good", 32'h0, {31'h0, tx_cfg_bad});
    chk("no match", 32'h0, {31'h0, link.rx_match});
    apb(1'b0, `DCL_IDX_STATUS, 32'h0);
    chk("status match", 32'h0, {31'h0, rd[7]});
    tx_load(4'h3, 1'b0, 1'b0);
    chk("wide mode", 32'h0, {31'h0, tx_cfg_bad});
    report_and_stop();
  end
endmodule
`default_nettype wire
